// ### ccm_bus_seq.sv
// Purpose: sequence one multiplexed bus cycle in clock phase steps
// Assumes: phase_en marks each phase of the processor clock
// Notes:   length is 6 + 2*ext + 2*(15-mctc) + 2*(1-mttc) phases
`timescale 1ns/1ps
module ccm_bus_seq
    import ccm_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       phase_en,
    input  wire logic       start,
    input  wire logic [1:0] ale_ext,
    input  wire logic [3:0] mctc,
    input  wire logic       mttc,
    input  wire logic       rw_delay,
    output logic            ale_r,
    output logic            strobe_r,
    output logic            busy_r,
    output logic [7:0]      last_len_r
);
    ccm_state_e  st_r;
    logic [5:0]  cnt_r;
    logic [7:0]  len_r;
    logic [5:0]  ale_ph;
    logic [5:0]  strb_ph;
    logic [5:0]  tri_ph;

    // Two phases of latch, extended by ext phases [R7]
    assign ale_ph  = 6'(2) + 6'(ale_ext);
    // Strobe: 3 base phases plus two per waitstate, minus one if delayed [R8] [R10]
    assign strb_ph = 6'(3) + 6'({CCM_WS_MAX - mctc, 1'b0}) - 6'(rw_delay);
    // Tristate after strobe: one phase, plus two when the tristate bit is clear [R7] [R9]
    assign tri_ph  = 6'(1) + 6'({~mttc, 1'b0});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= CCM_IDLE;
            cnt_r    <= 6'h00;
            len_r    <= 8'h00;
            ale_r    <= 1'b0;
            strobe_r <= 1'b0;
            busy_r   <= 1'b0;
            last_len_r <= 8'h00;
        end else if (phase_en) begin // [R1]
            len_r <= busy_r ? len_r + 8'h01 : 8'h01;
            case (st_r)
                CCM_IDLE: begin
                    if (start) begin
                        st_r   <= CCM_ALE;
                        ale_r  <= 1'b1;
                        busy_r <= 1'b1;
                        cnt_r  <= ale_ph - 6'h01;
                    end
                end
                CCM_ALE: begin
                    if (cnt_r == 6'h00) begin
                        ale_r <= 1'b0;
                        if (rw_delay || ale_ext != 2'h0) begin
                            st_r  <= CCM_ADDR;
                            cnt_r <= 6'(ale_ext) + 6'(rw_delay) - 6'h01;
                        end else begin
                            st_r     <= CCM_STRB; // [R10]
                            strobe_r <= 1'b1;
                            cnt_r    <= strb_ph - 6'h01;
                        end
                    end else begin
                        cnt_r <= cnt_r - 6'h01;
                    end
                end
                CCM_ADDR: begin
                    if (cnt_r == 6'h00) begin
                        st_r     <= CCM_STRB;
                        strobe_r <= 1'b1;
                        cnt_r    <= strb_ph - 6'h01;
                    end else begin
                        cnt_r <= cnt_r - 6'h01;
                    end
                end
                CCM_STRB: begin
                    if (cnt_r == 6'h00) begin
                        st_r     <= CCM_TRI;
                        strobe_r <= 1'b0;
                        cnt_r    <= tri_ph - 6'h01;
                    end else begin
                        cnt_r <= cnt_r - 6'h01;
                    end
                end
                CCM_TRI: begin
                    if (cnt_r == 6'h00) begin
                        st_r       <= CCM_IDLE;
                        busy_r     <= 1'b0;
                        last_len_r <= len_r; // [R9]
                    end else begin
                        cnt_r <= cnt_r - 6'h01;
                    end
                end
                default: st_r <= CCM_IDLE;
            endcase
        end
    end

    property p_len_formula;
        @(posedge pclk) disable iff (!presetn)
        (phase_en && st_r == CCM_TRI && cnt_r == 6'h00) |=>
            last_len_r == 8'(CCM_BASE_PH) + 8'({ale_ext, 1'b0})
                + 8'({CCM_WS_MAX - mctc, 1'b0}) + 8'({~mttc, 1'b0});
    endproperty
    a_len_formula: assert property (p_len_formula) else $error("bus cycle length wrong"); // [R9]

    // The latch strobe falling is the reference point for both strobe timings
    sequence s_ale_fall;
        $fell(ale_r);
    endsequence

    property p_strobe_nodelay;
        @(posedge pclk) disable iff (!presetn)
        s_ale_fall ##0 (!rw_delay && ale_ext == 2'h0) |-> strobe_r;
    endproperty
    a_strobe_nodelay: assert property (p_strobe_nodelay) else $error("strobe late"); // [R10]

    property p_strobe_delay;
        @(posedge pclk) disable iff (!presetn)
        s_ale_fall ##0 rw_delay |-> !strobe_r;
    endproperty
    a_strobe_delay: assert property (p_strobe_delay) else $error("strobe early"); // [R10]

    property p_ale_ext;
        @(posedge pclk) disable iff (!presetn)
        (phase_en && st_r == CCM_IDLE && start) |=> cnt_r == 6'(ale_ext) + 6'h01;
    endproperty
    a_ale_ext: assert property (p_ale_ext) else $error("latch stretch wrong"); // [R7]
endmodule

// ### ccm_ext_side.sv
// Purpose: pins and oscillator as the board around the block presents them
// Assumes: oscillator edges unrelated in phase to pclk
// Notes:   uneven duty cycle on purpose, so phase lengths reveal the clock mode
`timescale 1ns/1ps
module ccm_ext_side #(
    parameter int HI_NS = 24,
    parameter int LO_NS = 56
) (
    input  wire logic       long_reset_n,
    input  wire logic [7:0] cfg_pins,
    output logic            oscillator_input,
    output logic [7:0]      upper_port_zero_byte
);
    initial begin
        oscillator_input = 1'b0;
        #3;
        forever begin
            oscillator_input = 1'b1;
            #(HI_NS);
            oscillator_input = 1'b0;
            #(LO_NS);
        end
    end
    // Levels are frozen for the whole long reset, whatever the bench asks later
    always_latch begin
        if (long_reset_n) begin
            upper_port_zero_byte <= cfg_pins;
        end
    end
endmodule

// ### ccm_phase_gen.sv
// Purpose: make processor clock phase steps from the oscillator input
// Assumes: oscillator already synchronised to pclk
// Notes:   one phase step per oscillator edge (direct) or per period (prescaled)
`timescale 1ns/1ps
module ccm_phase_gen
    import ccm_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic osc_sync,
    input  wire logic prescale,
    output logic      cpu_clk_r,
    output logic      phase_en_r
);
    logic osc_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_d_r <= 1'b0;
        end else begin
            osc_d_r <= osc_sync;
        end
    end

    // Direct drive follows each oscillator edge, so duty cycle shapes phases [R5] [R6]
    // Prescaled toggles on rising edges only: every phase is one full period [R4]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_r  <= 1'b0;
            phase_en_r <= 1'b0;
        end else if (prescale) begin
            phase_en_r <= osc_sync & ~osc_d_r;
            if (osc_sync & ~osc_d_r) begin
                cpu_clk_r <= ~cpu_clk_r;
            end
        end else begin
            phase_en_r <= osc_sync ^ osc_d_r;
            cpu_clk_r  <= osc_sync;
        end
    end

    // In direct drive every phase boundary is an oscillator edge, so two consecutive phases add up to one period
    property p_pair_is_period;
        @(posedge pclk) disable iff (!presetn)
        (!$past(prescale) && !$past(prescale, 2)) |->
            phase_en_r == (cpu_clk_r ^ $past(cpu_clk_r));
    endproperty
    a_pair_is_period: assert property (p_pair_is_period) else $error("phase pair mismatch"); // [R6]

    property p_presc_rise;
        @(posedge pclk) disable iff (!presetn)
        (prescale && $past(prescale) && phase_en_r) |-> $past(osc_sync) && !$past(osc_d_r);
    endproperty
    a_presc_rise: assert property (p_presc_rise) else $error("prescaler phase without rise"); // [R4]

    property p_direct_follow;
        @(posedge pclk) disable iff (!presetn)
        (!prescale && !$past(prescale)) |-> cpu_clk_r == $past(osc_sync);
    endproperty
    a_direct_follow: assert property (p_direct_follow) else $error("direct drive lags"); // [R5]
endmodule

// ### ccm_pkg.sv
// Purpose: constants for the processor clock mode and bus phase timing block
// Assumes: pclk at 125 MHz, registers reached over APB, one word per register
// Notes:   each clock phase is one pclk-rate step when enabled
// Overview of operation
// R1 - Every phase of the processor clock, rising or falling, is a usable step for work.
// R2 - Bits 7 to 5 of the reset configuration latch choose how the processor clock is made. The code uses only bit 7; bits 6 and 5 are ignored.
// R3 - A long hardware reset loads the latch from the upper port zero byte, held by the outside.
// R4 - With select bit 7 set the oscillator is halved, each phase one oscillator period.
// R5 - With select bit 7 clear the oscillator passes straight through as the processor clock.
// R6 - In direct drive two consecutive phases always make exactly one oscillator period.
// R7 - The address-latch part is stretched by the extension count, tristate adds 2*(1-bit).
// R8 - Waitstates of two phases each are inserted, fifteen minus the cycle-time value of them.
// R9 - A bus cycle lasts 6 phases plus twice the extension plus waitstate and tristate time.
// R10 - With strobe delay the strobe asserts one phase after the latch strobe falls, else at it. The code adds the extension count to both.
// R11 - Software may read but never write the latch; it holds until the next long reset. The code also clears it to 00 on presetn.
package ccm_pkg;
    localparam logic [7:0] CCM_OFS_LATCH  = 8'h00;
    localparam logic [7:0] CCM_OFS_BUSCFG = 8'h04;
    localparam logic [7:0] CCM_OFS_CTRL   = 8'h08;
    localparam logic [7:0] CCM_OFS_STAT   = 8'h0C;
    localparam int         CCM_SEL_MSB    = 7;
    localparam int         CCM_SEL_LSB    = 5;
    localparam logic [7:0] CCM_LATCH_RST  = 8'h00;
    localparam logic [3:0] CCM_MCTC_RST   = 4'hF;
    localparam logic [3:0] CCM_BASE_PH    = 4'h6;
    localparam logic [3:0] CCM_WS_MAX     = 4'hF;
    localparam logic [7:0] CCM_BUSCFG_RST = 8'h2F;
    typedef enum logic [4:0] {
        CCM_IDLE  = 5'h01,
        CCM_ALE   = 5'h02,
        CCM_ADDR  = 5'h04,
        CCM_STRB  = 5'h08,
        CCM_TRI   = 5'h10
    } ccm_state_e;
    function automatic logic [7:0] ccm_word_sel(input logic [7:0] a, input logic [7:0] ofs);
        return {7'h00, a == ofs};
    endfunction
endpackage

// ### ccm_top.sv
// Purpose: processor clock mode selection and bus phase timing, with APB registers
// Assumes: long_reset_n marks a long hardware reset from the pins
// Notes:   processor clock is a pclk-domain waveform, phase steps are enables
`timescale 1ns/1ps
module ccm_top
    import ccm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        oscillator_input,
    input  wire logic [7:0]  upper_port_zero_byte,
    input  wire logic        long_reset_n,
    output logic             cpu_clk,
    output logic             phase_en,
    output logic             ale,
    output logic             rw_strobe
);
    logic [1:0]  osc_s_r;
    logic [1:0]  lrst_s_r;
    logic [7:0]  pins_s1_r;
    logic [7:0]  pins_s2_r;
    logic [7:0]  reset_config_latch_high_r;
    logic [7:0]  buscfg_r;
    logic        start_r;
    logic        busy;
    logic [7:0]  last_len;
    logic        ale_i;
    logic        strb_i;
    logic        cpu_clk_i;
    logic        phase_en_i;
    logic        ale_o_r;
    logic        strb_o_r;
    logic        cpu_o_r;
    logic        ph_o_r;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rdata_nxt;
    logic        err_nxt;
    logic [7:0]  hit;
    logic [2:0]  clock_source_select;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s_r   <= 2'h0;
            lrst_s_r  <= 2'h0;
            pins_s1_r <= 8'h00;
            pins_s2_r <= 8'h00;
        end else begin
            osc_s_r   <= {osc_s_r[0], oscillator_input};
            lrst_s_r  <= {lrst_s_r[0], long_reset_n};
            pins_s1_r <= upper_port_zero_byte;
            pins_s2_r <= pins_s1_r;
        end
    end

    // Captured while long reset is held; frozen afterwards, bus writes cannot reach it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_config_latch_high_r <= CCM_LATCH_RST;
        end else if (!lrst_s_r[1]) begin
            reset_config_latch_high_r <= pins_s2_r; // [R3] [R11]
        end
    end

    assign clock_source_select = reset_config_latch_high_r[CCM_SEL_MSB:CCM_SEL_LSB]; // [R2]

    ccm_phase_gen u_phase (
        .pclk       (pclk),
        .presetn    (presetn),
        .osc_sync   (osc_s_r[1]),
        .prescale   (clock_source_select[2]),
        .cpu_clk_r  (cpu_clk_i),
        .phase_en_r (phase_en_i)
    );

    // Bus config: [1:0] latch extension, [5:2] cycle-time value, [6] tristate, [7] delay
    ccm_bus_seq u_bus (
        .pclk       (pclk),
        .presetn    (presetn),
        .phase_en   (phase_en_i),
        .start      (start_r),
        .ale_ext    (buscfg_r[1:0]),
        .mctc       (buscfg_r[5:2]),
        .mttc       (buscfg_r[6]),
        .rw_delay   (buscfg_r[7]),
        .ale_r      (ale_i),
        .strobe_r   (strb_i),
        .busy_r     (busy),
        .last_len_r (last_len)
    );

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign hit   = {4'h0,
                    |ccm_word_sel(paddr, CCM_OFS_STAT),
                    |ccm_word_sel(paddr, CCM_OFS_CTRL),
                    |ccm_word_sel(paddr, CCM_OFS_BUSCFG),
                    |ccm_word_sel(paddr, CCM_OFS_LATCH)};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buscfg_r <= CCM_BUSCFG_RST;
        end else if (wr_en && hit[1]) begin
            buscfg_r <= pwdata[7:0];
        end
    end

    // Start request stays up until the sequencer takes it on a phase step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= 1'b0;
        end else if (wr_en && hit[2] && pwdata[0]) begin
            start_r <= 1'b1;
        end else if (phase_en_i && !busy) begin
            start_r <= 1'b0;
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        err_nxt   = 1'b0;
        case (1'b1)
            hit[0]:  rdata_nxt = {24'h00_0000, reset_config_latch_high_r}; // [R11]
            hit[1]:  rdata_nxt = {24'h00_0000, buscfg_r};
            hit[2]:  rdata_nxt = {31'h0000_0000, start_r};
            hit[3]:  rdata_nxt = {16'h0000, last_len, 7'h00, busy};
            default: err_nxt   = 1'b1;
        endcase
        if (pwrite && hit[0]) begin
            err_nxt = 1'b1;
        end
    end

    // No wait state: data registered in setup, answered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & err_nxt;
            if (rd_en) begin
                prdata <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_o_r  <= 1'b0;
            ph_o_r   <= 1'b0;
            ale_o_r  <= 1'b0;
            strb_o_r <= 1'b0;
        end else begin
            cpu_o_r  <= cpu_clk_i;
            ph_o_r   <= phase_en_i;
            ale_o_r  <= ale_i;
            strb_o_r <= strb_i;
        end
    end

    assign cpu_clk   = cpu_o_r;
    assign phase_en  = ph_o_r;
    assign ale       = ale_o_r;
    assign rw_strobe = strb_o_r;

    // Setup-cycle views of one access; the answer always follows one edge later
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence

    property p_latch_hold;
        @(posedge pclk) disable iff (!presetn)
        (lrst_s_r[1] && $past(lrst_s_r[1])) |-> $stable(reset_config_latch_high_r);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed outside reset"); // [R11]

    property p_latch_load;
        @(posedge pclk) disable iff (!presetn)
        !lrst_s_r[1] |=> reset_config_latch_high_r == $past(pins_s2_r);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch not loaded from pins"); // [R3]

    // Pin levels and the long reset only reach logic through both flops
    property p_lrst_sync;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn, 2) |-> lrst_s_r[1] == $past(long_reset_n, 2);
    endproperty
    a_lrst_sync: assert property (p_lrst_sync) else $error("long reset sync wrong"); // [R3]

    property p_pins_sync;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn, 2) |-> pins_s2_r == $past(upper_port_zero_byte, 2);
    endproperty
    a_pins_sync: assert property (p_pins_sync) else $error("pin sync wrong"); // [R3]

    property p_ready_after_setup;
        @(posedge pclk) disable iff (!presetn)
        s_setup |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");

    property p_ready_one_cycle;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("ready held");

    property p_idle_quiet;
        @(posedge pclk) disable iff (!presetn)
        !psel |=> !pready && !pslverr;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("answer without select");

    property p_latch_wr_refused;
        @(posedge pclk) disable iff (!presetn)
        s_setup ##0 (pwrite && paddr == CCM_OFS_LATCH) |=> pslverr;
    endproperty
    a_latch_wr_refused: assert property (p_latch_wr_refused) else $error("latch write taken"); // [R11]

    property p_unmapped_refused;
        @(posedge pclk) disable iff (!presetn)
        s_setup ##0 (hit == 8'h00) |=> pslverr;
    endproperty
    a_unmapped_refused: assert property (p_unmapped_refused) else $error("unmapped accepted");

    property p_latch_read;
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup ##0 (paddr == CCM_OFS_LATCH) |=>
            prdata == {24'h00_0000, $past(reset_config_latch_high_r)};
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // [R11]

    property p_stat_read;
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup ##0 (paddr == CCM_OFS_STAT) |=>
            prdata == {16'h0000, $past(last_len), 7'h00, $past(busy)};
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read wrong"); // [R9]

    property p_buscfg_write;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == CCM_OFS_BUSCFG) |=>
            buscfg_r == 8'($past(pwdata));
    endproperty
    a_buscfg_write: assert property (p_buscfg_write) else $error("bus config write lost"); // [R8]

    property p_start_set;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == CCM_OFS_CTRL && pwdata[0]) |=> start_r;
    endproperty
    a_start_set: assert property (p_start_set) else $error("start not set");

    property p_start_taken;
        @(posedge pclk) disable iff (!presetn)
        (start_r && phase_en_i && !busy) |=> busy;
    endproperty
    a_start_taken: assert property (p_start_taken) else $error("start not taken"); // [R1]

    property p_strobes_in_cycle;
        @(posedge pclk) disable iff (!presetn)
        (ale_i || strb_i) |-> busy;
    endproperty
    a_strobes_in_cycle: assert property (p_strobes_in_cycle) else $error("strobe when idle"); // [R9]

    property p_strobes_apart;
        @(posedge pclk) disable iff (!presetn)
        !(ale_i && strb_i);
    endproperty
    a_strobes_apart: assert property (p_strobes_apart) else $error("strobes overlap"); // [R10]

    // Outputs trail the internal waveforms by exactly one flop
    property p_out_clock;
        @(posedge pclk) disable iff (!presetn)
        cpu_clk == $past(cpu_clk_i) && phase_en == $past(phase_en_i);
    endproperty
    a_out_clock: assert property (p_out_clock) else $error("clock output skewed"); // [R1]

    property p_out_bus;
        @(posedge pclk) disable iff (!presetn)
        ale == $past(ale_i) && rw_strobe == $past(strb_i);
    endproperty
    a_out_bus: assert property (p_out_bus) else $error("strobe output skewed"); // [R10]

    property p_len_floor;
        @(posedge pclk) disable iff (!presetn)
        $fell(busy) |-> last_len >= 8'(CCM_BASE_PH);
    endproperty
    a_len_floor: assert property (p_len_floor) else $error("bus cycle too short"); // [R9]
endmodule

// ### ccm_top_test.sv
// Purpose: self-checking bench for clock mode and bus phase timing
// Assumes: oscillator period of 80 ns, ten pclk cycles
// Notes:   phase lengths are measured in pclk cycles at the outputs
`timescale 1ns/1ps
module ccm_top_test;
    import ccm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, long_reset_n;
    logic [7:0]  paddr, cfg_pins, upper_port_zero_byte;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, oscillator_input, cpu_clk, phase_en, ale, rw_strobe;
    int          mismatches, compares, hi, lo, pe, lag, n;
    int          tbl [4][4] = '{'{0, 15, 1, 0}, '{3, 0, 0, 1}, '{1, 7, 1, 0}, '{2, 15, 0, 1}};

    ccm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oscillator_input(oscillator_input),
        .upper_port_zero_byte(upper_port_zero_byte), .long_reset_n(long_reset_n),
        .cpu_clk(cpu_clk), .phase_en(phase_en), .ale(ale), .rw_strobe(rw_strobe));
    ccm_ext_side ext (.long_reset_n(long_reset_n), .cfg_pins(cfg_pins),
        .oscillator_input(oscillator_input), .upper_port_zero_byte(upper_port_zero_byte));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang();
        mismatches++;
        stop_test();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits for a given level on a design output, counting cycles and phase pulses
    task automatic until_lvl(ref logic s, input logic v, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (phase_en === 1'b1) pe++;
        end while (s !== v && n < 400);
        if (n >= 400) hang();
    endtask

    task automatic measure();
        int n;
        until_lvl(cpu_clk, 1'b0, n);
        until_lvl(cpu_clk, 1'b1, n);
        pe = 0;
        until_lvl(cpu_clk, 1'b0, hi);
        until_lvl(cpu_clk, 1'b1, lo);
    endtask

    task automatic long_reset(input logic [7:0] v);
        cfg_pins <= v;
        @(posedge pclk);
        long_reset_n <= 1'b0;
        repeat (8) @(posedge pclk);
        long_reset_n <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, presetn, long_reset_n} = 5'b00001;
        paddr = 8'h00;
        pwdata = 32'h0;
        cfg_pins = 8'h9A;
        mismatches = 0;
        compares = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        long_reset(8'h9A);
        apb(1'b0, CCM_OFS_LATCH, 32'h0);
        chk(rd, 32'h9A);
        apb(1'b0, CCM_OFS_BUSCFG, 32'h0);
        chk(rd, {24'h0, CCM_BUSCFG_RST});
        cfg_pins <= 8'h35;
        apb(1'b1, CCM_OFS_LATCH, 32'hFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, CCM_OFS_LATCH, 32'h0);
        chk(rd, 32'h9A);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        measure();
        chk(hi, 10);
        chk(lo, 10);
        chk(pe, 2);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, CCM_OFS_BUSCFG, tbl[i][0] | (tbl[i][1] << 2) | (tbl[i][2] << 6)
                | (tbl[i][3] << 7));
            apb(1'b1, CCM_OFS_CTRL, 32'h1);
            until_lvl(ale, 1'b1, lag);
            apb(1'b0, CCM_OFS_STAT, 32'h0);
            chk(rd[0], 1'b1);
            until_lvl(ale, 1'b0, lag);
            lag = 0;
            while (rw_strobe !== 1'b1 && lag < 100) begin
                @(posedge pclk);
                lag++;
            end
            chk(lag, 10 * (tbl[i][0] + tbl[i][3]));
            n = 0;
            do begin
                apb(1'b0, CCM_OFS_STAT, 32'h0);
                n++;
            end while (rd[0] !== 1'b0 && n < 300);
            if (n >= 300) hang();
            chk(rd[15:8], 6 + 2 * tbl[i][0] + 2 * (15 - tbl[i][1]) + 2 * (1 - tbl[i][2]));
        end
        long_reset(8'h35);
        apb(1'b0, CCM_OFS_LATCH, 32'h0);
        chk(rd, 32'h35);
        measure();
        chk(hi, 3);
        chk(hi + lo, 10);
        stop_test();
    end
endmodule
